// ---- hdl/smt_edge_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser with edge and level qualification by polarity
module smt_edge_sync
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Pin and polarity
  input wire logic pin_i,
  input wire logic pol_i,
  // Qualified outputs
  output logic active_o,
  output logic edge_o,
  output logic fall_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } smt_sync_t;

  smt_sync_t st_q;
  smt_sync_t st_d;

  // Shift chain; s1 is read only by s2
  always_comb
  begin
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // Polarity high means rising edge / high level is active
  assign active_o = st_q.s2 ~^ pol_i;
  assign edge_o = (st_q.s2 ~^ pol_i) & ~(st_q.s3 ~^ pol_i);
  assign fall_o = ~(st_q.s2 ~^ pol_i) & (st_q.s3 ~^ pol_i);
endmodule
`default_nettype wire

// ---- hdl/smt_timer.sv ----
// How it works
// - Continuous mode restarts the count at one after every reload.
// - A software start count only governs the first continuous pass.
// - Continuous mode counts prescaled system clocks, never the input pin.
// - Continuous period is reload value times prescale in system clocks.
// - A start other than one makes the first period start-to-reload.
// - Counter mode counts input pin edges, polarity bit picks edge.
// - Counter mode bypasses the prescaler; one edge adds exactly one.
// - Counter mode at reload raises interrupt, restarts at one, continues.
// - Counter mode toggles output pin at reload when output enabled.
// - Compare mode takes initial output level from control before enable.
// - Compare mode counts prescaled clocks; time is compare minus start.
// - Compare mode uses the reload register as compare value.
// - Gated mode counts only while input is at active level.
// - Gated mode interrupts on input going inactive and on reload.
// - Gated mode counts system clock up to 16-bit reload value.
// - Gated mode at reload sets count to one, continues if active.
// - Gated mode toggles output pin at reload when output enabled.
`timescale 1ns/100ps
`default_nettype none
module smt_timer
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Timer pins
  input wire logic timer_in_i,
  output logic timer_out_o,
  output logic timer_irq_o
);
  typedef enum logic [2:0] {
    SMT_IDLE = 3'b001,
    SMT_RUN = 3'b010,
    SMT_HALT = 3'b100
  } smt_state_t;

  typedef struct packed {
    smt_state_t state;
    logic [15:0] ctrl;
    logic [15:0] count;
    logic [15:0] reload;
    logic [6:0] pre;
    logic out;
    logic irq;
    logic fired;
    logic [15:0] rdata;
  } smt_regs_t;

  smt_regs_t r_q;
  smt_regs_t r_d;

  logic pin_active;
  logic pin_edge;
  logic pin_fall;

  // Tick limit per prescale exponent, picked by the exponent field; eight
  // small compares keep the prescaler a plain up-counter with no shifter
  // in its feedback path
  logic [7:0] pre_lim_hit;

  // Limit for exponent g is 2^g minus one clocks
  for (genvar g = 0; g < 8; g++)
  begin : g_pre
    assign pre_lim_hit[g] = (r_q.pre == 7'((8'h01 << g) - 8'h01));
  end

  // Mode decode, used for every mode flag below
  function automatic logic mode_is(input logic [15:0] ctrl,
                                   input logic [1:0] code);
    mode_is = (ctrl[smt_pkg::CTRL_MODE_LSB +: 2] == code);
  endfunction

  // Register index decode, shared by the read and the write path
  function automatic logic addr_is(input logic [3:0] addr,
                                   input logic [3:0] idx);
    addr_is = (addr == idx);
  endfunction

  // Read view of one register index; unmapped indices read as zero
  function automatic logic [15:0] read_view(input logic [3:0] addr,
                                            input smt_regs_t r,
                                            input logic [15:0] stat);
    logic [15:0] v;
    v = 16'h0000;
    if (addr_is(addr, smt_pkg::ADDR_CTRL))
      v = r.ctrl;
    if (addr_is(addr, smt_pkg::ADDR_COUNT))
      v = r.count;
    if (addr_is(addr, smt_pkg::ADDR_RELOAD))
      v = r.reload;
    if (addr_is(addr, smt_pkg::ADDR_STATUS))
      v = stat;
    read_view = v;
  endfunction

  // Pin input passes two flops before any logic reads it
  smt_edge_sync u_sync
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(timer_in_i),
    .pol_i(r_q.ctrl[smt_pkg::CTRL_POL_BIT]),
    .active_o(pin_active),
    .edge_o(pin_edge),
    .fall_o(pin_fall)
  );

  // Decoded control, advance and match terms
  logic en;
  logic [1:0] mode;
  logic [2:0] pre_sel;
  logic tick;
  logic adv;
  logic hit;
  logic rel_hit;
  logic cmp_hit;
  logic [15:0] count_inc;
  logic [6:0] pre_next;
  logic m_cont;
  logic m_counter;
  logic m_compare;
  logic m_gated;
  logic [15:0] status;

  // Control fields; before the enable bit is set only polarity and, in compare mode, the initial level act
  assign en = r_q.ctrl[smt_pkg::CTRL_EN_BIT];
  assign mode = r_q.ctrl[smt_pkg::CTRL_MODE_LSB +: 2];
  assign pre_sel = r_q.ctrl[smt_pkg::CTRL_PRE_LSB +: 3];
  assign tick = pre_lim_hit[pre_sel];

  // Status view: synced pin active state (level qualified by polarity), output level, sticky event flag
  assign status = {13'h0000, r_q.fired, r_q.out, pin_active};

  // One flag per mode, all from the same decode
  assign m_cont = mode_is(r_q.ctrl, smt_pkg::MODE_CONT);
  assign m_counter = mode_is(r_q.ctrl, smt_pkg::MODE_COUNTER);
  assign m_compare = mode_is(r_q.ctrl, smt_pkg::MODE_COMPARE);
  assign m_gated = mode_is(r_q.ctrl, smt_pkg::MODE_GATED);

  // Count advance source per mode; the pin paths bypass the prescaler
  always_comb
  begin
    adv = 1'b0;
    if (m_cont)
      adv = tick;
    if (m_counter)
      adv = pin_edge;
    if (m_compare)
      adv = tick;
    if (m_gated)
      adv = pin_active;
  end

  // Next count; wraps at 16 bits, so a reload below the start count
  // costs a full lap before the first match
  assign count_inc = 16'(r_q.count + 16'h0001);

  // Prescaler phase for the next cycle; back to zero on each tick
  assign pre_next = tick ? smt_pkg::PRE_ZERO : 7'(r_q.pre + 7'h01);

  // Reload modes match on the advance that finds the count at reload,
  // so a pass runs 1..reload and lasts reload advances
  assign rel_hit = adv && (r_q.count == r_q.reload);

  // Compare matches on the advance that brings the count up to the
  // compare value, so the time is compare minus start advances
  assign cmp_hit = adv && (count_inc == r_q.reload);

  // Compare mode uses the reload register as its compare value
  assign hit = m_compare ? cmp_hit : rel_hit;

  // Next-state logic. Order of precedence inside one cycle: read capture,
  // then the state machine, then software writes, so a write to the count
  // register overrides whatever counting did that cycle.
  // The irq register is a one-cycle pulse and is cleared at the top, so
  // each cycle with an event is one high cycle on the interrupt output; events in one cycle share it.
  always_comb
  begin
    r_d = r_q;
    r_d.irq = 1'b0;
    r_d.rdata = 16'h0000;
    // Read data stand for one cycle only and are zero otherwise
    if (rd_i)
      r_d.rdata = read_view(addr_i, r_q, status);
    case (r_q.state)
      SMT_IDLE:
      begin
        // Disabled: count holds, no event; in compare mode output tracks initial level
        // so the compare output starts from it on the first enabled cycle
        r_d.pre = smt_pkg::PRE_ZERO;
        if (m_compare)
          r_d.out = r_q.ctrl[smt_pkg::CTRL_INIT_BIT];
        if (en)
          r_d.state = SMT_RUN;
      end
      SMT_RUN:
      begin
        if (!en)
        begin
          // Leaving mid-period drops the prescale phase; the count stays
          // where it was, so a later enable resumes from it
          r_d.pre = smt_pkg::PRE_ZERO;
          r_d.state = SMT_IDLE;
        end
        else
        begin
          case (mode)
            smt_pkg::MODE_CONT:
            begin
              // Prescaled system clock; the first pass starts from the
              // loaded count, every later one from one, so only the
              // first period depends on what software loaded
              r_d.pre = pre_next;
              if (hit)
              begin
                r_d.irq = 1'b1;
                r_d.fired = 1'b1;
                if (r_q.ctrl[smt_pkg::CTRL_OUTEN_BIT])
                  r_d.out = ~r_q.out;
                r_d.count = smt_pkg::COUNT_RESTART;
              end
              else if (adv)
                r_d.count = count_inc;
            end
            smt_pkg::MODE_COUNTER:
            begin
              // Qualified pin edges only; the prescaler is parked so one
              // edge is exactly one count. Pins faster than half of
              // the clock rate lose edges in the synchroniser.
              r_d.pre = smt_pkg::PRE_ZERO;
              if (hit)
              begin
                r_d.irq = 1'b1;
                r_d.fired = 1'b1;
                if (r_q.ctrl[smt_pkg::CTRL_OUTEN_BIT])
                  r_d.out = ~r_q.out;
                r_d.count = smt_pkg::COUNT_RESTART;
              end
              else if (adv)
                r_d.count = count_inc;
            end
            smt_pkg::MODE_COMPARE:
            begin
              // One-shot compare: the count parks on the compare value
              // and the timer halts until software disables it; a start
              // at or above the compare value matches only after the count wraps
              r_d.pre = pre_next;
              if (hit)
              begin
                r_d.irq = 1'b1;
                r_d.fired = 1'b1;
                if (r_q.ctrl[smt_pkg::CTRL_OUTEN_BIT])
                  r_d.out = ~r_q.out;
                r_d.count = r_q.reload;
                r_d.state = SMT_HALT;
              end
              else if (adv)
                r_d.count = count_inc;
            end
            smt_pkg::MODE_GATED:
            begin
              // Every system clock while the gate is open; the gate
              // closing is an event of its own, even with no reload.
              // Gate edges reach the counter two to three clocks late.
              r_d.pre = smt_pkg::PRE_ZERO;
              if (hit)
              begin
                r_d.irq = 1'b1;
                r_d.fired = 1'b1;
                if (r_q.ctrl[smt_pkg::CTRL_OUTEN_BIT])
                  r_d.out = ~r_q.out;
                r_d.count = smt_pkg::COUNT_RESTART;
              end
              else if (adv)
                r_d.count = count_inc;
              if (pin_fall)
              begin
                r_d.irq = 1'b1;
                r_d.fired = 1'b1;
              end
            end
            default: r_d.pre = smt_pkg::PRE_ZERO;
          endcase
        end
      end
      SMT_HALT:
      begin
        // Compare done: hold until software disables the timer; the
        // output keeps its toggled level until then
        r_d.pre = smt_pkg::PRE_ZERO;
        if (!en)
          r_d.state = SMT_IDLE;
      end
      default: r_d.state = SMT_IDLE;
    endcase
    // Software writes come last and win over counting in the same cycle;
    // unmapped indices fall through every test and change nothing
    if (wr_i && addr_is(addr_i, smt_pkg::ADDR_CTRL))
      r_d.ctrl = wdata_i;
    if (wr_i && addr_is(addr_i, smt_pkg::ADDR_COUNT))
      r_d.count = wdata_i;
    if (wr_i && addr_is(addr_i, smt_pkg::ADDR_RELOAD))
      r_d.reload = wdata_i;
    // Clearing the sticky flag loses to an event in the same cycle, so
    // software never misses an event that lands on its own clear
    if (wr_i && addr_is(addr_i, smt_pkg::ADDR_STATUS) && wdata_i[2]
        && !r_d.irq)
      r_d.fired = 1'b0;
  end

  // One register for all state; synchronous reset puts every field at
  // its reset value, so the first cycle after release starts idle with
  // the timer disabled
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      r_q.state <= SMT_IDLE;
      r_q.ctrl <= smt_pkg::CTRL_RESET;
      r_q.count <= smt_pkg::COUNT_RESET;
      r_q.reload <= smt_pkg::RELOAD_RESET;
      r_q.pre <= smt_pkg::PRE_ZERO;
      r_q.out <= 1'b0;
      r_q.irq <= 1'b0;
      r_q.fired <= 1'b0;
      r_q.rdata <= 16'h0000;
    end
    else
      r_q <= r_d;
  end

  // Outputs straight from flops, so the pins and the read bus carry no
  // decode glitches; the cost is one cycle of latency on each
  assign rdata_o = r_q.rdata;
  assign timer_out_o = r_q.out;
  assign timer_irq_o = r_q.irq;
endmodule
`default_nettype wire

// ---- inc/smt_pkg.sv ----
package smt_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_COUNT = 4'h1;
  localparam logic [3:0] ADDR_RELOAD = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;

  // Control field positions
  localparam int CTRL_EN_BIT = 15;
  localparam int CTRL_POL_BIT = 14;
  localparam int CTRL_OUTEN_BIT = 13;
  localparam int CTRL_INIT_BIT = 12;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_PRE_LSB = 0;

  // Mode encodings in the control register
  localparam logic [1:0] MODE_CONT = 2'h0;
  localparam logic [1:0] MODE_COUNTER = 2'h1;
  localparam logic [1:0] MODE_COMPARE = 2'h2;
  localparam logic [1:0] MODE_GATED = 2'h3;

  // Values after reset and on reload
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0001;
  localparam logic [15:0] RELOAD_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [6:0] PRE_ZERO = 7'h00;
endpackage

// ---- tb/smt_pin_src.sv ----
`timescale 1ns/100ps
`default_nettype none
module smt_pin_src
(
  // Clock
  input wire logic clk_i,
  // Wave control
  input wire logic run_i,
  input wire logic lvl_i,
  input wire logic [3:0] half_i,
  // Pin
  output logic pin_o
);
  logic [3:0] cnt_q;
  // Square wave, or a held level; half period never under two clocks
  always_ff @(posedge clk_i)
  begin
    if (!run_i)
    begin
      pin_o <= lvl_i;
      cnt_q <= 4'h1;
    end
    else if (cnt_q >= half_i && cnt_q > 4'h1)
    begin
      pin_o <= !pin_o;
      cnt_q <= 4'h1;
    end
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule
`default_nettype wire

// ---- tb/smt_timer_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module smt_timer_props
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  // Timer pins
  input wire logic timer_in_i,
  input wire logic timer_out_o,
  input wire logic timer_irq_o
);
  logic [5:0] cf_q;
  logic [2:0] st_q;
  logic [1:0] md;
  assign md = cf_q[1:0];
  // Shadow of enable, polarity, output enable, initial level, mode;
  // the quiet-pin count saturates to stay small
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cf_q <= 6'h00;
      st_q <= 3'h0;
    end
    else
    begin
      if (wr_i && addr_i == smt_pkg::ADDR_CTRL)
        cf_q <= {wdata_i[15:12], wdata_i[5:4]};
      if (timer_in_i != $past(timer_in_i))
        st_q <= 3'h0;
      else if (st_q != 3'h7)
        st_q <= st_q + 3'h1;
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  a_off_quiet: assert property (
    !cf_q[5] && !$past(cf_q[5]) && !$past(cf_q[5], 2) |-> !timer_irq_o)
    else $error("irq while off");
  a_toggle_irq: assert property (
    cf_q[5] && $past(cf_q[5]) && $changed(timer_out_o) |-> timer_irq_o)
    else $error("out moved without irq");
  a_hold_out: assert property (
    cf_q[5] && $past(cf_q[5]) && !cf_q[3] |-> $stable(timer_out_o))
    else $error("out moved while output off");
  a_cmp_once: assert property (
    timer_irq_o && cf_q[5] && md == smt_pkg::MODE_COMPARE
    |=> !timer_irq_o [*8]) else $error("second compare irq");
  a_gate_hold: assert property (
    cf_q[5] && md == smt_pkg::MODE_GATED && timer_in_i != cf_q[4]
    && st_q == 3'h7 |-> !timer_irq_o) else $error("gated irq while held");
  a_gate_drop: assert property (
    cf_q[5] && md == smt_pkg::MODE_GATED && $fell(timer_in_i == cf_q[4])
    |-> ##[1:4] timer_irq_o) else $error("no irq on gate drop");
  a_cnt_still: assert property (
    cf_q[5] && md == smt_pkg::MODE_COUNTER && st_q == 3'h7
    |-> !timer_irq_o) else $error("counter irq without edges");
  a_cmp_init: assert property (
    $rose(cf_q[5]) && md == smt_pkg::MODE_COMPARE
    |-> timer_out_o == cf_q[2]) else $error("wrong initial out");
endmodule
bind smt_timer smt_timer_props u_props (.clk_i(clk_i), .reset_i(reset_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .timer_in_i(timer_in_i), .timer_out_o(timer_out_o),
  .timer_irq_o(timer_irq_o));
`default_nettype wire

// ---- tb/tb_smt_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_smt_timer;
  logic clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic wr_i = 1'h0, rd_i = 1'h0, run = 1'h0, lvl = 1'h0, rd_p = 1'h0;
  logic pin, pin_l, timer_out_o, timer_irq_o;
  logic [3:0] addr_i = 4'h0, half = 4'h3;
  logic [15:0] wdata_i = 16'h0000, c = 16'h0000, rdata_o, ex;
  logic [15:0] exp_q[$];
  int n_fail = 0, n_tests = 0, n_irq = 0, n_edge = 0, cyc = 0;
  int t_irq, t_prev, t0, seed = 23, r, p, d[2];
  always #12.5 clk_i = ~clk_i;
  smt_timer dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .timer_in_i(pin), .timer_out_o(timer_out_o), .timer_irq_o(timer_irq_o));
  smt_pin_src src (.clk_i(clk_i), .run_i(run), .lvl_i(lvl), .half_i(half),
    .pin_o(pin));
  // Irq times, counted pin edges, and read data against the oldest note
  always @(posedge clk_i)
  begin
    cyc++;
    if (timer_irq_o === 1'h1)
    begin
      n_irq++;
      t_prev = t_irq;
      t_irq = cyc;
    end
    if (pin !== pin_l && pin === c[14]) n_edge++;
    pin_l = pin;
    if (rd_p) check("rdata", rdata_o, exp_q.pop_front());
    rd_p = rd_i;
  end
  task automatic check(input string nm, input logic [15:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    {wr_i, rd_i, addr_i, wdata_i} <= {w, !w, a, v};
    @(posedge clk_i);
    {wr_i, rd_i} <= 2'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    acc(1'h0, a, 16'h0000);
  endtask
  // Disabled config first, start count and reload, enable last
  task automatic setup(input logic [15:0] cnt, rl);
    acc(1'h1, smt_pkg::ADDR_CTRL, c);
    acc(1'h1, smt_pkg::ADDR_COUNT, cnt);
    acc(1'h1, smt_pkg::ADDR_RELOAD, rl);
    n_irq = 0;
    n_edge = 0;
    t0 = cyc;
    acc(1'h1, smt_pkg::ADDR_CTRL, c | 16'h8000);
  endtask
  task automatic wait_irq(input int k);
    for (int i = 0; i < 3000 && n_irq < k; i++) @(posedge clk_i);
    if (n_irq < k)
    begin
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic wrap_up();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence: reset values, then each mode in turn
  initial
  begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'h0;
    rd(smt_pkg::ADDR_CTRL, smt_pkg::CTRL_RESET);
    rd(smt_pkg::ADDR_COUNT, smt_pkg::COUNT_RESET);
    rd(smt_pkg::ADDR_RELOAD, smt_pkg::RELOAD_RESET);
    rd(4'h9, 16'h0000);
    r = 5 + ($unsigned($random(seed)) % 6);
    p = $unsigned($random(seed)) % 3;
    half = 4'($unsigned($random(seed)) % 5);
    c = 16'(p);
    run <= 1'h1;
    setup(16'h0004, 16'(r));
    wait_irq(1);
    t0 = t_irq - t0;
    check("first", 16'(t0 >= (r - 4) << p && t0 <= ((r - 3) << p) + 6), 16'h0001);
    wait_irq(3);
    check("period", 16'(t_irq - t_prev), 16'(r << p));
    run <= 1'h0;
    for (int k = 0; k < 2; k++)
    begin
      lvl <= (k == 0);
      c = 16'h2010 | 16'(k << 14);
      setup(16'h0001, 16'h0004);
      run <= 1'h1;
      repeat (50 + 7 * k) @(posedge clk_i);
      run <= 1'h0;
      repeat (8) @(posedge clk_i);
      ex = 16'(1 + n_edge % 4);
      check("irqs", 16'(n_irq), 16'(n_edge / 4));
      rd(smt_pkg::ADDR_COUNT, ex);
      acc(1'h1, smt_pkg::ADDR_CTRL, c);
      run <= 1'h1;
      repeat (20) @(posedge clk_i);
      run <= 1'h0;
      rd(smt_pkg::ADDR_COUNT, ex);
    end
    for (int k = 0; k < 2; k++)
    begin
      c = 16'h3020 | 16'(2 * k);
      setup(16'h0002, 16'h0006);
      wait_irq(1);
      d[k] = t_irq - t0;
      repeat (12) @(posedge clk_i);
      check("cmp irqs", 16'(n_irq), 16'h0001);
      check("cmp out", 16'(timer_out_o), 16'h0000);
    end
    check("cmp time", 16'(d[1] - d[0]), 16'h000C);
    // Gated: seven active clocks past a reload of five, then a drop
    c = 16'h6030;
    setup(16'h0001, 16'h0005);
    repeat (6) @(posedge clk_i);
    lvl <= 1'h1;
    repeat (7) @(posedge clk_i);
    lvl <= 1'h0;
    repeat (10) @(posedge clk_i);
    check("gate irqs", 16'(n_irq), 16'h0002);
    rd(smt_pkg::ADDR_COUNT, 16'h0003);
    rd(smt_pkg::ADDR_STATUS, 16'h0006);
    acc(1'h1, smt_pkg::ADDR_STATUS, 16'h0004);
    rd(smt_pkg::ADDR_STATUS, 16'h0002);
    repeat (2) @(posedge clk_i);
    wrap_up();
  end
endmodule
`default_nettype wire
